// ### rtl/dsisf_defs.svh
// constants of the sensor fault/status block and its bus master
`ifndef DSISF_DEFS_SVH
`define DSISF_DEFS_SVH

`define DSISF_CLK_MHZ 50
// command identifiers
`define DSISF_CMD_READ 4'h1
`define DSISF_CMD_CLEAR 4'h5
`define DSISF_CMD_DIS_ST 4'hc
`define DSISF_CMD_EN_ST 4'hd
`define DSISF_CMD_RSVD14 4'he
`define DSISF_CMD_REVINIT 4'hf
`define DSISF_ADDR_GLOBAL 4'h0
// status word bit positions
`define DSISF_BIT_S 1
`define DSISF_BIT_AT0 2
`define DSISF_BIT_AT1 3
`define DSISF_BIT_ST 5
`define DSISF_BIT_U 6
`define DSISF_BIT_NV 7
`define DSISF_ADDR_LSB 12
`define DSISF_ADDR_MSB 15
`define DSISF_CFG1_AT_LSB 0
`define DSISF_CFG1_AT_MSB 1
// fault timing in microseconds
`define DSISF_HOLD_CAPACITOR_NODE_TO_US 1000
`define DSISF_CAPTEST_US 1000
`define DSISF_FRAME_TO_US 1000
// controller register map and fields
`define DSISF_REG_CMD 4'h0
`define DSISF_REG_STATUS 4'h4
`define DSISF_REG_RSP 4'h8
`define DSISF_REG_BUS 4'hc
`define DSISF_F_ID_LSB 0
`define DSISF_F_ID_MSB 3
`define DSISF_F_ADDR_LSB 4
`define DSISF_F_ADDR_MSB 7
`define DSISF_F_LONG 8
`define DSISF_F_DATA_LSB 16
`define DSISF_F_DATA_MSB 23
`define DSISF_ST_BUSY 0
`define DSISF_ST_DONE 1
`define DSISF_ST_NOANS 2
`define DSISF_ST_LONG 3
`define DSISF_RSP_WAIT 8'h10
`define DSISF_RESP_OKAY 2'h0
`define DSISF_RESP_SLVERR 2'h2

`endif

// ### rtl/dsisf_pkg.sv
// types shared by the sensor device end and the bus master end
package dsisf_pkg;
    typedef logic [3:0] dsisf_nib_t;
    typedef logic [7:0] dsisf_byte_t;
    typedef logic [15:0] dsisf_word_t;
    typedef logic [31:0] dsisf_axi_t;
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b01,
        CTL_WAIT = 2'b10
    } dsisf_ctl_state_t;
endpackage

// ### rtl/dsisf_link_if.sv
// frame-level link between bus master and sensor
`timescale 1ns/1ps
interface dsisf_link_if;
    logic cmd_valid;
    logic [3:0] cmd_id;
    logic [3:0] cmd_addr;
    logic cmd_long;
    logic [7:0] cmd_data;
    logic bus_low;
    logic rsp_valid;
    logic rsp_long;
    logic [15:0] rsp_data;
    modport dev (input cmd_valid, cmd_id, cmd_addr, cmd_long, cmd_data, bus_low,
                 output rsp_valid, rsp_long, rsp_data);
    modport ctl (output cmd_valid, cmd_id, cmd_addr, cmd_long, cmd_data, bus_low,
                 input rsp_valid, rsp_long, rsp_data);
endinterface

// ### rtl/dsisf_device.sv
// sensor end: status flags, fault responses, repeating resets, selftest lockout
`timescale 1ns/1ps
`include "dsisf_defs.svh"
module dsisf_device #(
    parameter int HOLD_CAPACITOR_NODE_TO_CYC = `DSISF_HOLD_CAPACITOR_NODE_TO_US * `DSISF_CLK_MHZ,
    parameter int CAPTEST_CYC = `DSISF_CAPTEST_US * `DSISF_CLK_MHZ,
    parameter int FRAME_TO_CYC = `DSISF_FRAME_TO_US * `DSISF_CLK_MHZ
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    dsisf_link_if.dev link,
    input wire logic digital_regulator_low_i,
    input wire logic analog_regulator_low_i,
    input wire logic hold_capacitor_node_low_i,
    input wire logic cap_test_fail_i,
    input wire logic factory_crc_fail_i,
    input wire logic user_crc_fail_i,
    input wire logic temp_fault_i,
    input wire logic otp_prog_en_i,
    input wire dsisf_pkg::dsisf_byte_t device_config_reg_one_i,
    input wire dsisf_pkg::dsisf_nib_t own_addr_i,
    input wire dsisf_pkg::dsisf_word_t accel_short_i,
    input wire dsisf_pkg::dsisf_word_t accel_long_i,
    output logic selftest_drive_o,
    output logic selftest_lockout_o,
    output logic in_reset_o,
    output logic reset_pulse_o
);
    import dsisf_pkg::*;

    localparam int NTMR = 3;
    localparam int TMR_HOLD_CAPACITOR_NODE = 0;
    localparam int TMR_CAP = 1;
    localparam int TMR_FRAME = 2;

    logic [NTMR-1:0] tmr_lvl;
    logic [NTMR-1:0] tmr_dead;
    logic [NTMR-1:0] tmr_pulse;
    logic core_rst;
    logic dead;
    logic st_en;
    logic lockout;
    logic last_dis;
    logic st_now;
    logic addr_own;
    logic addr_glob;
    logic id_ignored;
    logic cmd_take;
    logic zero_short;
    logic err_flag;
    dsisf_word_t status_word;
    dsisf_word_t next_rsp_data;
    logic rsp_valid;
    logic rsp_long;
    dsisf_word_t rsp_data;

    // fault levels watched by the repeating reset timers
    assign tmr_lvl[TMR_HOLD_CAPACITOR_NODE] = hold_capacitor_node_low_i;
    assign tmr_lvl[TMR_CAP] = cap_test_fail_i;
    assign tmr_lvl[TMR_FRAME] = link.bus_low;

    // one timer per fault: counts while the fault stands, resets each interval
    for (genvar g = 0; g < NTMR; g++) begin : g_tmr
        localparam int LIM = (g == TMR_HOLD_CAPACITOR_NODE) ? HOLD_CAPACITOR_NODE_TO_CYC :
                             (g == TMR_CAP) ? CAPTEST_CYC : FRAME_TO_CYC;
        logic [31:0] cnt;
        logic dead_r;
        logic pulse_r;
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                cnt <= 32'h0;
                dead_r <= 1'b0;
                pulse_r <= 1'b0;
            end else if (ce_i) begin
                pulse_r <= 1'b0;
                if (!tmr_lvl[g]) begin
                    cnt <= 32'h0;
                    dead_r <= 1'b0;
                end else if (cnt == 32'(LIM - 1)) begin
                    cnt <= 32'h0;
                    dead_r <= 1'b1;
                    pulse_r <= 1'b1;
                end else begin
                    cnt <= cnt + 32'h1;
                end
            end
        end
        // one driver per vector bit, from this timer only
        assign tmr_dead[g] = dead_r;
        assign tmr_pulse[g] = pulse_r;
    end

    // device held in reset: supplies low, timed-out cap or frame, cap test fail
    assign dead = digital_regulator_low_i | analog_regulator_low_i
                | tmr_dead[TMR_HOLD_CAPACITOR_NODE]
                | cap_test_fail_i
                | tmr_dead[TMR_FRAME];
    assign core_rst = srst_i | dead | (|tmr_pulse);

    // command qualification
    assign addr_own = (link.cmd_addr == own_addr_i);
    assign addr_glob = (link.cmd_addr == `DSISF_ADDR_GLOBAL);
    assign id_ignored = (link.cmd_id == `DSISF_CMD_RSVD14)
                      | (link.cmd_id == `DSISF_CMD_REVINIT);
    assign cmd_take = link.cmd_valid & !dead & !id_ignored
                    & (addr_own | (addr_glob & (link.cmd_id != `DSISF_CMD_EN_ST)));

    // selftest enable and lockout
    always_ff @(posedge mclk_i) begin
        if (core_rst) begin
            st_en <= 1'b0;
            lockout <= 1'b0;
            last_dis <= 1'b0;
        end else if (ce_i) begin
            if (cmd_take) begin
                case (link.cmd_id)
                    `DSISF_CMD_EN_ST: begin
                        if (!lockout) begin
                            st_en <= 1'b1;
                        end
                        last_dis <= 1'b0;
                    end
                    `DSISF_CMD_DIS_ST: begin
                        st_en <= 1'b0;
                        if (last_dis) begin
                            lockout <= 1'b1;
                        end
                        last_dis <= 1'b1;
                    end
                    `DSISF_CMD_CLEAR: begin
                        st_en <= 1'b0;
                        lockout <= 1'b0;
                        last_dis <= 1'b0;
                    end
                    default: begin
                        last_dis <= 1'b0;
                    end
                endcase
            end
            if (hold_capacitor_node_low_i) begin
                lockout <= 1'b0; // lockout also ends on cap undervoltage
            end
        end
    end

    // selftest state once the command now taken has acted; answers report it
    always_comb begin
        st_now = st_en;
        if (cmd_take && link.cmd_id == `DSISF_CMD_EN_ST && !lockout) begin
            st_now = 1'b1;
        end else if (cmd_take && (link.cmd_id == `DSISF_CMD_DIS_ST
                                  || link.cmd_id == `DSISF_CMD_CLEAR)) begin
            st_now = 1'b0;
        end
    end

    // error flag: otp crc, temperature, selftest unless cap dip masks it
    assign err_flag = factory_crc_fail_i
                    | user_crc_fail_i
                    | temp_fault_i
                    | (st_now & !hold_capacitor_node_low_i);

    // short data zeroed by any fault; selftest keeps data through a cap dip
    assign zero_short = factory_crc_fail_i | user_crc_fail_i | temp_fault_i
                      | (hold_capacitor_node_low_i & !st_now);

    // status word as sent in responses
    always_comb begin
        status_word = 16'h0000;
        status_word[`DSISF_BIT_S] = err_flag;
        status_word[`DSISF_BIT_ST] = st_now;
        status_word[`DSISF_BIT_U] = hold_capacitor_node_low_i;
        status_word[`DSISF_BIT_NV] = otp_prog_en_i;
        status_word[`DSISF_BIT_AT1:`DSISF_BIT_AT0] =
            device_config_reg_one_i[`DSISF_CFG1_AT_MSB:`DSISF_CFG1_AT_LSB];
        if (link.cmd_long) begin
            status_word[`DSISF_ADDR_MSB:`DSISF_ADDR_LSB] = own_addr_i;
        end
    end

    // response payload: acceleration for reads, status otherwise
    always_comb begin
        next_rsp_data = status_word;
        if (link.cmd_id == `DSISF_CMD_READ) begin
            if (link.cmd_long) begin
                next_rsp_data = accel_long_i;
            end else if (zero_short) begin
                next_rsp_data = 16'h0000;
            end else begin
                next_rsp_data = accel_short_i;
            end
        end
    end

    // one-cycle answer after an addressed command
    always_ff @(posedge mclk_i) begin
        if (core_rst) begin
            rsp_valid <= 1'b0;
            rsp_long <= 1'b0;
            rsp_data <= 16'h0000;
        end else if (ce_i) begin
            rsp_valid <= cmd_take & addr_own;
            if (cmd_take & addr_own) begin
                rsp_long <= link.cmd_long;
                rsp_data <= next_rsp_data;
            end
        end
    end

    assign link.rsp_valid = rsp_valid;
    assign link.rsp_long = rsp_long;
    assign link.rsp_data = rsp_data;
    assign selftest_drive_o = st_en;
    assign selftest_lockout_o = lockout;
    assign in_reset_o = dead;
    assign reset_pulse_o = |tmr_pulse;
endmodule

// ### rtl/dsisf_ctl.sv
// master end: axi4-lite registers, frame issue, answer wait
`timescale 1ns/1ps
`include "dsisf_defs.svh"
module dsisf_ctl (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    dsisf_link_if.ctl link,
    input wire logic [3:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire dsisf_pkg::dsisf_axi_t s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [3:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output dsisf_pkg::dsisf_axi_t s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    import dsisf_pkg::*;

    dsisf_ctl_state_t state;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    dsisf_axi_t w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic launch;
    logic clr_done;
    logic clr_noans;
    logic done;
    logic noans;
    logic bus_low;
    logic [7:0] wait_cnt;
    logic cmd_valid;
    dsisf_nib_t cmd_id;
    dsisf_nib_t cmd_addr;
    logic cmd_long;
    dsisf_byte_t cmd_data;
    logic rsp_long;
    dsisf_word_t rsp_data;
    dsisf_axi_t next_rdata;
    logic rd_hit;

    // write address and data taken in either order
    assign s_axi_awready_o = !aw_held & !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held & !s_axi_bvalid_o;
    assign wr_fire = aw_held & w_held & !s_axi_bvalid_o;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `DSISF_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr == `DSISF_REG_CMD || aw_addr == `DSISF_REG_STATUS ||
                                  aw_addr == `DSISF_REG_BUS) ? `DSISF_RESP_OKAY
                                                             : `DSISF_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // register write effects
    assign launch = wr_fire & (aw_addr == `DSISF_REG_CMD) & (state == CTL_IDLE) & w_strb[0];
    assign clr_done = wr_fire & (aw_addr == `DSISF_REG_STATUS) & w_data[`DSISF_ST_DONE];
    assign clr_noans = wr_fire & (aw_addr == `DSISF_REG_STATUS) & w_data[`DSISF_ST_NOANS];

    // bus line control: software can pull the bus below frame threshold
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bus_low <= 1'b0;
        end else if (ce_i && wr_fire && aw_addr == `DSISF_REG_BUS) begin
            bus_low <= w_data[0];
        end
    end

    // frame issue and answer wait
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= CTL_IDLE;
            wait_cnt <= 8'h0;
            cmd_valid <= 1'b0;
            cmd_id <= 4'h0;
            cmd_addr <= 4'h0;
            cmd_long <= 1'b0;
            cmd_data <= 8'h0;
        end else if (ce_i) begin
            cmd_valid <= 1'b0;
            case (state)
                CTL_IDLE: begin
                    if (launch) begin
                        cmd_valid <= 1'b1;
                        cmd_id <= w_data[`DSISF_F_ID_MSB:`DSISF_F_ID_LSB];
                        cmd_addr <= w_data[`DSISF_F_ADDR_MSB:`DSISF_F_ADDR_LSB];
                        cmd_long <= w_data[`DSISF_F_LONG];
                        cmd_data <= w_data[`DSISF_F_DATA_MSB:`DSISF_F_DATA_LSB];
                        wait_cnt <= 8'h0;
                        // global frames get no answer
                        if (w_data[`DSISF_F_ADDR_MSB:`DSISF_F_ADDR_LSB] != `DSISF_ADDR_GLOBAL) begin
                            state <= CTL_WAIT;
                        end
                    end
                end
                CTL_WAIT: begin
                    wait_cnt <= wait_cnt + 8'h1;
                    if (link.rsp_valid || wait_cnt == `DSISF_RSP_WAIT) begin
                        state <= CTL_IDLE;
                    end
                end
                default: begin
                    state <= CTL_IDLE;
                end
            endcase
        end
    end

    // sticky answer and no-answer flags, set beats clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            done <= 1'b0;
            noans <= 1'b0;
            rsp_long <= 1'b0;
            rsp_data <= 16'h0000;
        end else if (ce_i) begin
            if (state == CTL_WAIT && link.rsp_valid) begin
                done <= 1'b1;
                rsp_long <= link.rsp_long;
                rsp_data <= link.rsp_data;
            end else if (clr_done) begin
                done <= 1'b0;
            end
            if (state == CTL_WAIT && !link.rsp_valid && wait_cnt == `DSISF_RSP_WAIT) begin
                noans <= 1'b1;
            end else if (clr_noans) begin
                noans <= 1'b0;
            end
        end
    end

    // read path
    assign rd_hit = (s_axi_araddr_i == `DSISF_REG_CMD) || (s_axi_araddr_i == `DSISF_REG_STATUS)
                 || (s_axi_araddr_i == `DSISF_REG_RSP) || (s_axi_araddr_i == `DSISF_REG_BUS);
    always_comb begin
        next_rdata = 32'h0;
        case (s_axi_araddr_i)
            `DSISF_REG_CMD: begin
                next_rdata[`DSISF_F_ID_MSB:`DSISF_F_ID_LSB] = cmd_id;
                next_rdata[`DSISF_F_ADDR_MSB:`DSISF_F_ADDR_LSB] = cmd_addr;
                next_rdata[`DSISF_F_LONG] = cmd_long;
                next_rdata[`DSISF_F_DATA_MSB:`DSISF_F_DATA_LSB] = cmd_data;
            end
            `DSISF_REG_STATUS: begin
                next_rdata[`DSISF_ST_BUSY] = (state == CTL_WAIT) | cmd_valid;
                next_rdata[`DSISF_ST_DONE] = done;
                next_rdata[`DSISF_ST_NOANS] = noans;
                next_rdata[`DSISF_ST_LONG] = rsp_long;
            end
            `DSISF_REG_RSP: begin
                next_rdata[15:0] = rsp_data;
            end
            `DSISF_REG_BUS: begin
                next_rdata[0] = bus_low;
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `DSISF_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i & s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= next_rdata;
                s_axi_rresp_o <= rd_hit ? `DSISF_RESP_OKAY : `DSISF_RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    assign link.cmd_valid = cmd_valid;
    assign link.cmd_id = cmd_id;
    assign link.cmd_addr = cmd_addr;
    assign link.cmd_long = cmd_long;
    assign link.cmd_data = cmd_data;
    assign link.bus_low = bus_low;
endmodule

// ### tb/dsisf_link_assertions.sv
// concurrent checks on the link between the bus master end and the sensor end
`timescale 1ns/1ps
module dsisf_link_assertions (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_id,
    input wire logic [3:0] cmd_addr,
    input wire logic rsp_valid,
    input wire logic rsp_long,
    input wire logic [15:0] rsp_data,
    input wire dsisf_pkg::dsisf_nib_t own_addr_i,
    input wire dsisf_pkg::dsisf_byte_t device_config_reg_one_i,
    input wire logic otp_prog_en_i,
    input wire logic hold_capacitor_node_low_i,
    input wire logic digital_regulator_low_i,
    input wire logic analog_regulator_low_i,
    input wire logic in_reset_o,
    input wire logic selftest_drive_o,
    input wire logic selftest_lockout_o
);
    import dsisf_pkg::*;
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    // replies to anything but a read carry the status word
    logic stat;
    assign stat = rsp_valid && cmd_id != 4'h1;
    chk_id14_silent: assert property (cmd_valid && cmd_id == 4'he |=> !rsp_valid)
        else $error("answer to command 1110");
    chk_id15_silent: assert property (cmd_valid && cmd_id == 4'hf |=> !rsp_valid)
        else $error("answer to command 1111");
    chk_global_st: assert property (cmd_valid && cmd_id == 4'hd && cmd_addr == 4'h0 |=> !rsp_valid)
        else $error("answer to global selftest enable");
    chk_held_reset: assert property (digital_regulator_low_i || analog_regulator_low_i |-> in_reset_o)
        else $error("regulator low without reset");
    chk_reset_mute: assert property (cmd_valid && in_reset_o |=> !rsp_valid)
        else $error("answer while in reset");
    chk_st_flag: assert property (stat |-> rsp_data[5] == selftest_drive_o)
        else $error("selftest flag differs from drive");
    chk_cap_flag: assert property (stat |-> rsp_data[6] == $past(hold_capacitor_node_low_i))
        else $error("capacitor flag wrong");
    chk_otp_flag: assert property (stat |-> rsp_data[7] == $past(otp_prog_en_i))
        else $error("otp enable flag wrong");
    chk_attr_copy: assert property (stat |-> rsp_data[3:2] == $past(device_config_reg_one_i[1:0]))
        else $error("attribute field wrong");
    chk_long_addr: assert property (stat && rsp_long |-> rsp_data[15:12] == $past(own_addr_i))
        else $error("address field wrong");
    chk_lock_st_off: assert property ($rose(selftest_lockout_o) |-> !selftest_drive_o [*4])
        else $error("selftest on under lockout");
endmodule

// ### tb/test_dsi_sensor_fault_status_response.sv
// bench joining the bus master end and the sensor end over the link
`timescale 1ns/1ps
module test_dsi_sensor_fault_status_response;
    import dsisf_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    // response readies stay high for the whole run
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b1, ar_v = 1'b0, r_r = 1'b1;
    logic ce = 1'b1;
    logic [3:0] strb = 4'hf;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, st_drv, st_lock, in_rst, rst_pulse;
    logic [3:0] aw_a = 4'h0, ar_a = 4'h0, own = 4'h1;
    logic [1:0] rresp, bresp;
    dsisf_axi_t w_d = 32'h0, rdata;
    logic hold_capacitor_node = 1'b0, otp = 1'b0, fcrc = 1'b0, ucrc = 1'b0, tmp = 1'b0;
    logic [4:0] flt = 5'h0;
    dsisf_byte_t cfg = 8'h0;
    dsisf_word_t acs = 16'h0, acl = 16'h0;
    logic st = 1'b0, lock = 1'b0, dis_last = 1'b0, dead = 1'b0, rl = 1'b0;
    logic [3:0] ids [6] = '{4'h1, 4'h5, 4'hd, 4'hc, 4'he, 4'hf};
    logic [3:0] seq [9] = '{4'hc, 4'hc, 4'hd, 4'h5, 4'hd, 4'h1, 4'h1, 4'hc, 4'hc};
    int err_count = 0, checks_done = 0, pulses = 0;
    int seed = 32'hc94ea4fb;
    logic [33:0] exp_q [$];
    logic [1:0] bq [$];
    always #10 mclk_i = ~mclk_i;
    dsisf_link_if link ();
    dsisf_ctl i_dsisf_ctl (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .link(link.ctl),
        .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
        .s_axi_wdata_i(w_d), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r));
    dsisf_device #(.HOLD_CAPACITOR_NODE_TO_CYC(40), .CAPTEST_CYC(8), .FRAME_TO_CYC(8)) i_dsisf_device (
        .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce), .link(link.dev),
        .digital_regulator_low_i(flt[0]), .analog_regulator_low_i(flt[1]), .hold_capacitor_node_low_i(hold_capacitor_node | flt[4]),
        .cap_test_fail_i(flt[2]), .factory_crc_fail_i(fcrc), .user_crc_fail_i(ucrc),
        .temp_fault_i(tmp), .otp_prog_en_i(otp), .device_config_reg_one_i(cfg),
        .own_addr_i(own), .accel_short_i(acs), .accel_long_i(acl),
        .selftest_drive_o(st_drv), .selftest_lockout_o(st_lock), .in_reset_o(in_rst),
        .reset_pulse_o(rst_pulse));
    dsisf_link_assertions i_dsisf_link_assertions (
        .mclk_i(mclk_i), .srst_i(srst_i), .cmd_valid(link.cmd_valid), .cmd_id(link.cmd_id),
        .cmd_addr(link.cmd_addr), .rsp_valid(link.rsp_valid), .rsp_long(link.rsp_long),
        .rsp_data(link.rsp_data), .own_addr_i(own), .device_config_reg_one_i(cfg),
        .otp_prog_en_i(otp), .hold_capacitor_node_low_i(hold_capacitor_node | flt[4]), .digital_regulator_low_i(flt[0]),
        .analog_regulator_low_i(flt[1]), .in_reset_o(in_rst), .selftest_drive_o(st_drv),
        .selftest_lockout_o(st_lock));
    // verdict and end of run
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // axi write, both channels offered together, held until taken
    task automatic wr(input logic [3:0] a, input dsisf_axi_t d);
        bq.push_back((a == 4'h0 || a == 4'h4 || a == 4'hc) ? 2'h0 : 2'h2);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
    endtask
    // axi read, the expected reply noted for the monitor
    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        ar_a <= a;
        ar_v <= 1'b1;
        do @(posedge mclk_i); while (!ar_rdy);
        ar_v <= 1'b0;
        while (!r_v) @(posedge mclk_i);
    endtask
    // one frame round trip with the reference state updated and read back
    task automatic cmd(input logic [3:0] id, input logic [3:0] ad, input logic lg, input logic hc);
        logic tk;
        logic ans;
        dsisf_word_t r;
        hold_capacitor_node <= hc;
        wr(4'h4, 32'h6);
        tk = !dead && id < 4'he && (ad == own || (ad == 4'h0 && id != 4'hd));
        ans = tk && ad == own;
        if (hc) lock = 1'b0;
        if (tk && id == 4'hd && !lock) st = 1'b1;
        if (tk && id == 4'hc) begin
            lock = lock | dis_last;
            st = 1'b0;
        end
        if (tk && id == 4'h5) begin
            st = 1'b0;
            lock = 1'b0;
        end
        if (tk) dis_last = id == 4'hc;
        if (id == 4'h1) r = lg ? acl : (fcrc | ucrc | tmp | (hc & !st)) ? 16'h0 : acs;
        else r = {lg ? own : 4'h0, 4'h0, otp, hc, st, 1'b0, cfg[1:0], fcrc | ucrc | tmp | (st & !hc), 1'b0};
        wr(4'h0, {8'h0, 8'($random(seed)), 7'h0, lg, ad, id});
        repeat (8) @(posedge mclk_i);
        hold_capacitor_node <= 1'b0;
        repeat (16) @(posedge mclk_i);
        if (ans) rl = lg;
        rd(4'h4, {30'h0, rl, !ans && ad != 4'h0, ans, 1'b0});
        if (ans) rd(4'h8, {18'h0, r});
        cmp({32'h0, lock, st}, {32'h0, st_lock, st_drv});
    endtask
    // compare each read with the oldest note, count repeating resets
    always @(posedge mclk_i) begin
        if (rst_pulse === 1'b1) pulses++;
        if (r_v === 1'b1 && r_r && exp_q.size() > 0) cmp(exp_q.pop_front(), {rresp, rdata});
        if (b_v === 1'b1 && b_r && bq.size() > 0) cmp({32'h0, bq.pop_front()}, {32'h0, bresp});
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [3:0] ad;
        repeat (12) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        // random fields, faults, command ids and addresses
        for (int i = 0; i < 30; i++) begin
            {otp, fcrc, ucrc, tmp} <= 4'($random(seed));
            cfg <= 8'($random(seed));
            own <= 4'($random(seed)) | 4'h1;
            acs <= 16'($random(seed));
            acl <= 16'($random(seed));
            @(posedge mclk_i);
            ad = (i % 7 == 2) ? 4'h0 : (i % 7 == 5) ? own ^ 4'h8 : own;
            cmd(ids[i % 6], ad, i[1], i % 4 == 2);
        end
        {otp, fcrc, ucrc, tmp} <= 4'h0;
        rd(4'h1, {2'b10, 32'h0});
        // frame write without byte lane 0 must not launch; read-only write refused
        strb <= 4'he;
        wr(4'h0, {23'h0, 1'b0, own, 4'h1});
        strb <= 4'hf;
        rd(4'h4, {30'h0, rl, 1'b1, 1'b0, 1'b0});
        wr(4'h8, 32'hffffffff);
        // lockout, clear, selftest data and a dip with selftest on
        foreach (seq[k]) cmd(seq[k], own, k[0], k == 6);
        // enable low: cap timer and lockout frozen despite a long cap dip
        ce <= 1'b0;
        flt <= 5'h10;
        pulses = 0;
        repeat (60) @(posedge mclk_i);
        cmp({31'h0, lock, st, 1'b0}, {31'h0, st_lock, st_drv, in_rst | (pulses > 0)});
        ce <= 1'b1;
        // held and repeating resets, then recovery and selftest after reset
        for (int f = 0; f < 5; f++) begin
            flt <= 5'(1 << f);
            pulses = 0;
            @(posedge mclk_i);
            wr(4'hc, {31'h0, f == 3});
            repeat (90) @(posedge mclk_i);
            {dead, st, lock, dis_last} = 4'h8;
            cmd(4'h1, own, 1'b0, f == 4);
            cmp({33'h0, f > 1}, {33'h0, pulses > 1});
            flt <= 5'h0;
            wr(4'hc, 32'h0);
            repeat (20) @(posedge mclk_i);
            dead = 1'b0;
            cmd(4'hd, own, 1'b1, 1'b0);
        end
        wrap_up();
    end
endmodule
